// ---- rtl/phy_loop_pkg.sv ----
/*
 * Shared constants and carriers of the loopback, error-count and
 * energy power-down register bank.
 * Assumes a 10 MHz management clock and 5-bit register addresses.
 */
package phy_loop_pkg;

    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;

    // register addresses on the management port
    localparam logic [4:0] LOOP_CTRL_ADDR   = 5'h13;
    localparam logic [4:0] RX_ERR_ADDR      = 5'h14;
    localparam logic [4:0] ENERGY_CTRL_ADDR = 5'h15;

    // reset values and writable masks
    localparam logic [15:0] LOOP_CTRL_RESET   = 16'h1041;
    localparam logic [15:0] LOOP_CTRL_WMASK   = 16'hf7c1;
    localparam logic [15:0] RX_ERR_RESET      = 16'h0000;
    localparam logic [15:0] ENERGY_CTRL_RESET = 16'h0000;
    localparam logic [15:0] ENERGY_CTRL_WMASK = 16'h000d;
    localparam logic [15:0] ERR_MAX           = 16'hffff;

    // field positions, loopback register
    localparam int unsigned ALL_DIG_BIT    = 12;
    localparam int unsigned LINE_DRV_BIT   = 10;
    localparam int unsigned REMOTE_BIT     = 9;
    localparam int unsigned ISOLATE_BIT    = 8;
    localparam int unsigned EXT_CABLE_BIT  = 7;
    localparam int unsigned TX_SUPP_BIT    = 6;
    localparam int unsigned LINK_FORCE_BIT = 0;

    // field positions, energy register
    localparam int unsigned PD_ENABLE_BIT = 3;
    localparam int unsigned PD_PULSE_BIT  = 2;
    localparam int unsigned PD_FLAG_BIT   = 1;

    // energy power-down timing, idle and gap in milliseconds, pulse length plus one in cycles
    localparam int unsigned IDLE_MS       = 3000;
    localparam int unsigned PULSE_GAP_MS  = 1000;
    localparam int unsigned PULSE_LEN_CYC = 16;
    localparam logic [31:0] IDLE_CYC      = 32'(IDLE_MS * CYCLES_PER_MS);
    localparam logic [31:0] PULSE_GAP_CYC = 32'(PULSE_GAP_MS * CYCLES_PER_MS);

    typedef enum logic [1:0] {
        PD_ACTIVE,
        PD_ASLEEP,
        PD_PULSING
    } pd_state_t;

    // one management register request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } mgmt_req_t;

    // one symbol of the byte-wide data path
    typedef struct packed {
        logic       en;
        logic       er;
        logic [7:0] d;
    } symbol_t;

endpackage : phy_loop_pkg

// ---- rtl/phy_loopback_energy_ctrl.sv ----
/*
 * Loopback control, receive error counter and energy-detect power-down
 * registers with their effect on the MAC and line data paths.
 * Assumes the basic-control loopback bit, link state, energy detect and
 * the frame checker error pulse arrive synchronous to clock.
 */
`timescale 1ns/1ps

module phy_loopback_energy_ctrl #(
    parameter logic [31:0] IDLE_CYCLES      = phy_loop_pkg::IDLE_CYC,
    parameter logic [31:0] PULSE_GAP_CYCLES = phy_loop_pkg::PULSE_GAP_CYC
) (
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire phy_loop_pkg::mgmt_req_t mgmtReq,
    output logic [15:0]                  mgmtRdata,
    input  wire logic                    basicLoopback,
    input  wire logic                    linkUp,
    input  wire logic                    energyDetected,
    input  wire logic                    energyStrap,
    input  wire logic                    checkerError,
    input  wire phy_loop_pkg::symbol_t   macTx,
    input  wire phy_loop_pkg::symbol_t   lineRx,
    output phy_loop_pkg::symbol_t        macRx,
    output phy_loop_pkg::symbol_t        lineTx,
    output logic                         macLinkOk,
    output logic                         lineDriverMode,
    output logic                         echoCancelOff,
    output logic                         inPowerdown,
    output logic                         wakePulse
);

    typedef struct packed {
        logic [15:0]            loopCtrl;
        logic [15:0]            errCount;
        logic [15:0]            energyCtrl;
        logic                   strapTaken;
        phy_loop_pkg::pd_state_t pdState;
        logic [31:0]            timer;
        logic [15:0]            rdata;
        phy_loop_pkg::symbol_t  macRx;
        phy_loop_pkg::symbol_t  lineTx;
        logic                   linkOk;
        logic                   lineDrv;
        logic                   echoOff;
        logic                   pdFlag;
        logic                   pulse;
    } state_t;

    state_t stateReg;
    state_t stateNext;

    // masked write: only writable bits change
    function automatic logic [15:0] masked(input logic [15:0] old,
                                           input logic [15:0] wdat,
                                           input logic [15:0] mask);
        masked = (old & ~mask) | (wdat & mask);
    endfunction : masked

    logic digLoop;
    logic ldLoop;
    logic remoteLoop;
    logic extLoop;
    logic anyLoop;
    logic rdErr;
    logic [15:0] energyView;

    // loop mode decode from the register, the basic loopback bit and link state
    always_comb begin
        ldLoop = basicLoopback && stateReg.loopCtrl[phy_loop_pkg::LINE_DRV_BIT];
        digLoop = basicLoopback && !ldLoop
                  && stateReg.loopCtrl[phy_loop_pkg::ALL_DIG_BIT];
        remoteLoop = linkUp && stateReg.loopCtrl[phy_loop_pkg::REMOTE_BIT];
        // cable loop, relies on basic clear
        extLoop = !basicLoopback
                  && stateReg.loopCtrl[phy_loop_pkg::EXT_CABLE_BIT];
        anyLoop = basicLoopback || remoteLoop || extLoop;
        rdErr   = mgmtReq.rd && (mgmtReq.addr == phy_loop_pkg::RX_ERR_ADDR);
        energyView = stateReg.energyCtrl;
        energyView[phy_loop_pkg::PD_FLAG_BIT] = stateReg.pdFlag;
    end

    always_comb begin
        stateNext = stateReg;

        // register writes; reserved read-only bits masked out
        if (mgmtReq.wr) begin
            unique case (mgmtReq.addr)
                phy_loop_pkg::LOOP_CTRL_ADDR: begin
                    stateNext.loopCtrl = masked(stateReg.loopCtrl,
                        mgmtReq.wdata, phy_loop_pkg::LOOP_CTRL_WMASK);
                end
                phy_loop_pkg::ENERGY_CTRL_ADDR: begin
                    stateNext.energyCtrl = masked(stateReg.energyCtrl,
                        mgmtReq.wdata, phy_loop_pkg::ENERGY_CTRL_WMASK);
                end
                default: begin
                end
            endcase
        end

        // strap caught once, first edge after reset release
        if (!stateReg.strapTaken) begin
            stateNext.energyCtrl[phy_loop_pkg::PD_ENABLE_BIT] = energyStrap;
            stateNext.strapTaken = 1'b1;
        end

        // registered read data, answered one cycle after the strobe
        if (mgmtReq.rd) begin
            unique case (mgmtReq.addr)
                phy_loop_pkg::LOOP_CTRL_ADDR:   stateNext.rdata = stateReg.loopCtrl;
                phy_loop_pkg::RX_ERR_ADDR:      stateNext.rdata = stateReg.errCount;
                phy_loop_pkg::ENERGY_CTRL_ADDR: stateNext.rdata = energyView;
                default:                        stateNext.rdata = 16'h0000;
            endcase
        end

        // error counter; saturates so a wrap never hides errors
        // checker runs only with diagnostics clock
        if (rdErr) begin
            stateNext.errCount = checkerError ? 16'h0001 : 16'h0000;
        end else if (checkerError && stateReg.errCount != phy_loop_pkg::ERR_MAX) begin
            stateNext.errCount = stateReg.errCount + 16'h0001;
        end

        // energy-detect power-down sequencer
        stateNext.pulse = 1'b0;
        unique case (stateReg.pdState)
            phy_loop_pkg::PD_ACTIVE: begin
                if (energyDetected
                    || !stateReg.energyCtrl[phy_loop_pkg::PD_ENABLE_BIT]) begin
                    stateNext.timer = 32'h0;
                end else if (stateReg.timer >= IDLE_CYCLES - 32'h1) begin
                    stateNext.pdState = phy_loop_pkg::PD_ASLEEP;
                    stateNext.timer   = 32'h0;
                end else begin
                    stateNext.timer = stateReg.timer + 32'h1;
                end
            end
            phy_loop_pkg::PD_ASLEEP: begin
                if (energyDetected
                    || !stateReg.energyCtrl[phy_loop_pkg::PD_ENABLE_BIT]) begin
                    stateNext.pdState = phy_loop_pkg::PD_ACTIVE;
                    stateNext.timer   = 32'h0;
                end else if (!stateReg.energyCtrl[phy_loop_pkg::PD_PULSE_BIT]) begin
                    stateNext.timer = 32'h0;
                end else if (stateReg.timer >= PULSE_GAP_CYCLES - 32'h1) begin
                    stateNext.pdState = phy_loop_pkg::PD_PULSING;
                    stateNext.timer   = 32'h0;
                    stateNext.pulse   = 1'b1;
                end else begin
                    stateNext.timer = stateReg.timer + 32'h1;
                end
            end
            phy_loop_pkg::PD_PULSING: begin
                // burst is cut short by energy or by disabling power-down
                if (energyDetected
                    || !stateReg.energyCtrl[phy_loop_pkg::PD_ENABLE_BIT]) begin
                    stateNext.pdState = phy_loop_pkg::PD_ACTIVE;
                    stateNext.timer   = 32'h0;
                end else if (stateReg.timer >= 32'(phy_loop_pkg::PULSE_LEN_CYC - 2)) begin
                    stateNext.pdState = phy_loop_pkg::PD_ASLEEP;
                    stateNext.timer   = 32'h0;
                end else begin
                    stateNext.timer = stateReg.timer + 32'h1;
                    stateNext.pulse = 1'b1;
                end
            end
            default: begin
                stateNext.pdState = phy_loop_pkg::PD_ACTIVE;
            end
        endcase
        stateNext.pdFlag = (stateNext.pdState != phy_loop_pkg::PD_ACTIVE);

        // receive path toward the MAC
        if (digLoop) begin
            stateNext.macRx = macTx;
        end else begin
            stateNext.macRx = lineRx;
        end
        if (anyLoop && stateReg.loopCtrl[phy_loop_pkg::ISOLATE_BIT]) begin
            stateNext.macRx = '0;
        end

        // transmit path toward the line
        if (remoteLoop) begin
            stateNext.lineTx = lineRx;
        end else if (digLoop && stateReg.loopCtrl[phy_loop_pkg::TX_SUPP_BIT]) begin
            stateNext.lineTx = '0;
        end else begin
            stateNext.lineTx = macTx;
        end
        if (stateNext.pdFlag) begin
            stateNext.lineTx = '0; // driver off while asleep
        end

        stateNext.linkOk = linkUp || (basicLoopback
            && stateReg.loopCtrl[phy_loop_pkg::LINK_FORCE_BIT]);
        // reflection mode to analog front end
        stateNext.lineDrv = ldLoop;
        stateNext.echoOff = extLoop;
    end

    // single register stage for all state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stateReg            <= '0;
            stateReg.loopCtrl   <= phy_loop_pkg::LOOP_CTRL_RESET;
            stateReg.errCount   <= phy_loop_pkg::RX_ERR_RESET;
            stateReg.energyCtrl <= phy_loop_pkg::ENERGY_CTRL_RESET;
            stateReg.pdState    <= phy_loop_pkg::PD_ACTIVE;
        end else begin
            stateReg <= stateNext;
        end
    end

    // outputs straight from flip-flops
    assign mgmtRdata      = stateReg.rdata;
    assign macRx          = stateReg.macRx;
    assign lineTx         = stateReg.lineTx;
    assign macLinkOk      = stateReg.linkOk;
    assign lineDriverMode = stateReg.lineDrv;
    assign echoCancelOff  = stateReg.echoOff;
    assign inPowerdown    = stateReg.pdFlag;
    assign wakePulse      = stateReg.pulse;

endmodule : phy_loopback_energy_ctrl

// ---- dv/phy_loop_partner.sv ----
/* stand-in for the MAC transmit side and the remote line partner.
   assumes it shares the block's clock; needs no reset. */
`timescale 1ns/1ps
module phy_loop_partner (
    input  wire logic            clock,
    output phy_loop_pkg::symbol_t macTx,
    output phy_loop_pkg::symbol_t lineRx
);
    logic [7:0] cntReg = 8'h00;
    // new symbol every cycle, so a stuck path cannot hide
    always @(posedge clock) begin
        cntReg <= cntReg + 8'h01;
    end
    // two distinct patterns keep the sources apart
    assign macTx  = '{en: 1'b1, er: 1'b0, d: cntReg};
    assign lineRx = '{en: 1'b1, er: 1'b1, d: ~cntReg};
endmodule : phy_loop_partner

// ---- dv/phy_loop_assertions.sv ----
/* checker: port properties of the loopback and power-down bank.
   assumes it is bound to every instance of the top module. */
`timescale 1ns/1ps
module phy_loop_assertions (
    input wire logic                    clock,
    input wire logic                    rst,
    input wire phy_loop_pkg::mgmt_req_t mgmtReq,
    input wire logic [15:0]             mgmtRdata,
    input wire logic                    basicLoopback,
    input wire logic                    linkUp,
    input wire logic                    energyDetected,
    input wire logic                    checkerError,
    input wire logic                    macLinkOk,
    input wire logic                    lineDriverMode,
    input wire logic                    echoCancelOff,
    input wire logic                    inPowerdown,
    input wire logic                    wakePulse
);
    logic cntRd;
    logic mapped;
    // counter reads and decoded addresses
    assign cntRd  = mgmtReq.rd && mgmtReq.addr == phy_loop_pkg::RX_ERR_ADDR;
    assign mapped = mgmtReq.addr inside {5'h13, 5'h14, 5'h15};
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_link; linkUp |=> macLinkOk; endproperty
    a_link: assert property (p_link) else $error("link status lost");
    property p_ldm; lineDriverMode |-> $past(basicLoopback); endproperty
    a_ldm: assert property (p_ldm) else $error("reflection mode");
    property p_eco; echoCancelOff |-> !$past(basicLoopback); endproperty
    a_eco: assert property (p_eco) else $error("echo cancel off");
    property p_pin; wakePulse |-> inPowerdown; endproperty
    a_pin: assert property (p_pin) else $error("pulse when awake");
    property p_plen; $rose(wakePulse) |-> wakePulse [*8]; endproperty
    a_plen: assert property (p_plen) else $error("pulse too short");
    property p_wake; energyDetected |=> !inPowerdown; endproperty
    a_wake: assert property (p_wake) else $error("no wake on energy");
    property p_sleep;
        $rose(inPowerdown) |-> !$past(energyDetected) && !$past(energyDetected, 2);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep with energy");
    property p_clr; cntRd && !checkerError ##1 cntRd |=> mgmtRdata == 16'h0000;
    endproperty
    a_clr: assert property (p_clr) else $error("count not cleared");
    property p_keep; cntRd && checkerError ##1 cntRd |=> mgmtRdata == 16'h0001;
    endproperty
    a_keep: assert property (p_keep) else $error("error lost");
    property p_unmap; mgmtReq.rd && !mapped |=> mgmtRdata == 16'h0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped data");
    property p_hold; !mgmtReq.rd |=> $stable(mgmtRdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    c_keep: cover property (cntRd && checkerError);
    c_pulse: cover property ($rose(wakePulse));
    c_ldm: cover property (lineDriverMode);
    c_eco: cover property (echoCancelOff);
endmodule : phy_loop_assertions

bind phy_loopback_energy_ctrl phy_loop_assertions i_phy_loop_assertions (
    .clock(clock), .rst(rst), .mgmtReq(mgmtReq), .mgmtRdata(mgmtRdata),
    .basicLoopback(basicLoopback), .linkUp(linkUp),
    .energyDetected(energyDetected), .checkerError(checkerError),
    .macLinkOk(macLinkOk), .lineDriverMode(lineDriverMode),
    .echoCancelOff(echoCancelOff), .inPowerdown(inPowerdown),
    .wakePulse(wakePulse)
);

// ---- dv/phy_loopback_energy_ctrl_tb_top.sv ----
/* self-checking bench for the loopback, error-count and power-down bank.
   assumes the partner model and the bound checker sit beside the block. */
`timescale 1ns/1ps
module phy_loopback_energy_ctrl_tb_top;
    typedef struct packed {
        logic [15:0] r;
        logic        b;
        logic        l;
        logic [1:0]  rs;
        logic [1:0]  ts;
        logic [2:0]  f;
    } row_t;
    localparam logic [4:0] CTL = phy_loop_pkg::LOOP_CTRL_ADDR;
    localparam logic [4:0] CNT = phy_loop_pkg::RX_ERR_ADDR;
    localparam logic [4:0] PWR = phy_loop_pkg::ENERGY_CTRL_ADDR;
    // basic bit set for digital, clear for cable
    localparam row_t ROWS [8] = '{
        '{16'h1041, 1'b1, 1'b0, 2'h1, 2'h0, 3'h1},
        '{16'h1000, 1'b1, 1'b0, 2'h1, 2'h1, 3'h0},
        '{16'h1400, 1'b1, 1'b0, 2'h2, 2'h1, 3'h4},
        '{16'h1100, 1'b1, 1'b0, 2'h0, 2'h1, 3'h0},
        '{16'h0200, 1'b0, 1'b1, 2'h2, 2'h2, 3'h1},
        '{16'h0080, 1'b0, 1'b0, 2'h2, 2'h1, 3'h2},
        '{16'h0180, 1'b0, 1'b0, 2'h0, 2'h1, 3'h2},
        '{16'h0000, 1'b0, 1'b1, 2'h2, 2'h1, 3'h1}};
    logic                    clock, rst, basicLoopback, linkUp, checkerError;
    logic                    energyDetected, energyStrap, macLinkOk;
    logic                    lineDriverMode, echoCancelOff, inPowerdown;
    logic                    wakePulse;
    logic [15:0]             mgmtRdata, v;
    phy_loop_pkg::mgmt_req_t mgmtReq;
    phy_loop_pkg::symbol_t   macTx, lineRx, macRx, lineTx, pTx, pRx;
    int                      badCount, testsRun, n;

    phy_loopback_energy_ctrl #(.IDLE_CYCLES(32'h14), .PULSE_GAP_CYCLES(32'h0a))
    i_phy_loopback_energy_ctrl (.clock(clock), .rst(rst), .mgmtReq(mgmtReq),
        .mgmtRdata(mgmtRdata), .basicLoopback(basicLoopback), .linkUp(linkUp),
        .energyDetected(energyDetected), .energyStrap(energyStrap),
        .checkerError(checkerError), .macTx(macTx), .lineRx(lineRx),
        .macRx(macRx), .lineTx(lineTx), .macLinkOk(macLinkOk),
        .lineDriverMode(lineDriverMode), .echoCancelOff(echoCancelOff),
        .inPowerdown(inPowerdown), .wakePulse(wakePulse));
    phy_loop_partner i_phy_loop_partner (.clock(clock), .macTx(macTx),
        .lineRx(lineRx));

    // 100 ns clock; symbols captured mid-cycle, before the edge uses them
    always #50 clock = ~clock;
    always @(negedge clock) begin
        pTx <= macTx;
        pRx <= lineRx;
    end

    task automatic closeOut();
        $display("compares %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : closeOut
    task automatic chk(input string s, input logic [15:0] e, g);
        testsRun++;
        if (g !== e) begin
            badCount++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock);
        mgmtReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        mgmtReq.wr <= 1'b0;
    endtask : wr
    // read held for k edges; the last answer is returned
    task automatic rdn(input logic [4:0] a, input int k);
        @(posedge clock);
        mgmtReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        repeat (k) @(posedge clock);
        mgmtReq.rd <= 1'b0;
        #1 v = mgmtRdata;
    endtask : rdn
    // bounded wait on power-down or on a wake pulse
    task automatic waitHi(input logic p);
        for (n = 0; !(p ? wakePulse : inPowerdown); n++) begin
            if (n == 80) begin
                badCount++;
                closeOut();
            end
            @(posedge clock);
            #1;
        end
    endtask : waitHi
    function automatic logic [15:0] pick(input logic [1:0] s);
        return s == 2'h1 ? 16'(pTx) : s == 2'h2 ? 16'(pRx) : 16'h0000;
    endfunction : pick

    // main sequence
    initial begin
        {rst, energyDetected, energyStrap} = 3'h7;
        {basicLoopback, linkUp, checkerError} = 3'h0;
        mgmtReq = '0;
        {clock, badCount, testsRun} = '0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rdn(CTL, 1); chk("ctl reset", 16'h1041, v);
        rdn(PWR, 1); chk("pwr strap", 16'h0008, v);
        wr(CTL, 16'hffff); rdn(CTL, 1); chk("ctl mask", 16'hf7c1, v);
        wr(PWR, 16'hfff0); rdn(PWR, 1); chk("pwr mask", 16'h0000, v);
        wr(5'h10, 16'hffff); rdn(5'h10, 1); chk("unmapped", 16'h0000, v);
        wr(CNT, 16'hffff); rdn(CNT, 1); chk("cnt write", 16'h0000, v);
        $display("register access done");
        for (int i = 0; i < 8; i++) begin
            wr(CTL, ROWS[i].r);
            basicLoopback <= ROWS[i].b;
            linkUp <= ROWS[i].l;
            repeat (2) @(posedge clock);
            #1;
            chk("macRx", pick(ROWS[i].rs), 16'(macRx));
            chk("lineTx", pick(ROWS[i].ts), 16'(lineTx));
            chk("modes", 16'(ROWS[i].f), 16'({lineDriverMode, echoCancelOff,
                macLinkOk}));
            $display("loop row %0d done", i);
        end
        // diagnostics clock taken as running; four single errors
        repeat (4) begin
            @(posedge clock) checkerError <= 1'b1;
            @(posedge clock) checkerError <= 1'b0;
        end
        rdn(CNT, 1); chk("count", 16'h0004, v);
        rdn(CNT, 2); chk("count cleared", 16'h0000, v);
        // error landing on the clearing read
        repeat (2) begin
            @(posedge clock) checkerError <= 1'b1;
            @(posedge clock) checkerError <= 1'b0;
        end
        @(posedge clock);
        mgmtReq <= '{wr: 1'b0, rd: 1'b1, addr: CNT, wdata: 16'h0000};
        checkerError <= 1'b1;
        @(posedge clock) checkerError <= 1'b0;
        #1 chk("count", 16'h0002, mgmtRdata);
        @(posedge clock) mgmtReq.rd <= 1'b0;
        #1 chk("count restart", 16'h0001, mgmtRdata);
        $display("error counter done");
        wr(PWR, 16'h000d);
        energyDetected <= 1'b0;
        waitHi(1'b0);
        chk("line quiet", 16'h0000, 16'(lineTx));
        rdn(PWR, 1); chk("pwr flag", 16'h000f, v);
        waitHi(1'b1);
        for (n = 0; wakePulse && n < 40; n++) @(posedge clock) #1;
        chk("pulse length", 16'h000f, 16'(n));
        @(posedge clock) energyDetected <= 1'b1;
        repeat (2) @(posedge clock);
        #1 chk("awake", 16'h0000, 16'(inPowerdown));
        $display("power-down done");
        // strap low this time, so the enable default must follow it
        @(posedge clock);
        rst <= 1'b1;
        energyStrap <= 1'b0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rdn(CTL, 1); chk("ctl reset", 16'h1041, v);
        rdn(PWR, 1); chk("pwr strap", 16'h0000, v);
        $display("second reset done");
        closeOut();
    end
endmodule : phy_loopback_energy_ctrl_tb_top
